/* lcrqs_pkg.sv */
// package of constants and types for the lc rotation quadrature sampler
package lcrqs_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_MASK       = 8'h08;
  localparam logic [7:0]  ADDR_REF_LOW    = 8'h0C;
  localparam logic [7:0]  ADDR_REF_HIGH   = 8'h10;
  localparam logic [7:0]  ADDR_POSITION   = 8'h14;
  localparam logic [7:0]  ADDR_ERRCNT     = 8'h18;
  localparam logic [7:0]  ADDR_SCAN_DIV   = 8'h1C;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_RECAL_BIT  = 1;
  localparam int          ST_MOTION_BIT   = 0;
  localparam int          ST_SCAN_END_BIT = 1;
  localparam int          ST_ERROR_BIT    = 2;
  localparam int          LEVEL_W         = 12;
  localparam logic [11:0] REF_LOW_RST     = 12'h700;
  localparam logic [11:0] REF_HIGH_RST    = 12'h900;
  localparam logic [2:0]  MASK_RST        = 3'h0;

  // ----------------------------------------------------------------------
  // timing: 500 Hz scan trigger at a 250 MHz clock
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ          = 250_000_000;
  localparam int          SCAN_RATE_HZ    = 500;
  localparam logic [31:0] SCAN_DIV_RST    = 32'(CLK_HZ / SCAN_RATE_HZ);

  typedef enum logic [1:0] {
    LCRQS_IDLE,
    LCRQS_CH0,
    LCRQS_CH1,
    LCRQS_DONE
  } lcrqs_scan_t;

endpackage

/* lcrqs_chan_if.sv */
// interface between the sampler core and the hysteresis channel slice
`timescale 1ns/100ps
interface lcrqs_chan_if;
  logic [11:0] level;
  logic [11:0] ref_low;
  logic [11:0] ref_high;
  logic        sample;
  logic        bit_out;
  modport core  (output level, output ref_low, output ref_high,
                 output sample, input bit_out);
  modport slice (input level, input ref_low, input ref_high,
                 input sample, output bit_out);
endinterface

/* lcrqs_hyst.sv */
// per-channel hysteresis comparator with switched reference
`timescale 1ns/100ps
module lcrqs_hyst (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  lcrqs_chan_if.slice      ch
);

  logic out_bit;
  logic next_out;
  logic below_low;
  logic above_high;

  assign below_low  = ch.level < ch.ref_low;
  assign above_high = ch.level > ch.ref_high;
  // high uses lower reference, low uses upper reference
  assign next_out   = out_bit ? !below_low : above_high;
  assign ch.bit_out = out_bit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_bit <= 1'b1;
    end else if (ch.sample) begin
      out_bit <= next_out;
    end
  end

endmodule

/* lcrqs_top.sv */
// lc rotation quadrature sampler: scan timing, quadrature decode, ahb regs
`timescale 1ns/100ps
module lcrqs_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [11:0] i_level,
  input  wire logic        i_level_valid,
  output logic             o_excite,
  output logic             o_sel_ch1,
  output logic [1:0]       o_state,
  output logic             o_irq,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic        run_en;
  logic        recal_mode;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [11:0] ref_low;
  logic [11:0] ref_high;
  logic [15:0] position;
  logic [15:0] err_cnt;
  logic [31:0] scan_div;

  // ----------------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_take;
  logic [31:0] rd_mux;

  assign addr_take   = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_take && i_hwrite;
      wr_addr <= i_haddr[7:0];
    end
  end

  assign rd_mux =
    (i_haddr[7:0] == lcrqs_pkg::ADDR_CTRL)     ? {30'h0, recal_mode, run_en} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_STATUS)   ? {29'h0, status} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_MASK)     ? {29'h0, mask} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_REF_LOW)  ? {20'h0, ref_low} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_REF_HIGH) ? {20'h0, ref_high} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_POSITION) ? {14'h0, o_state, position} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_ERRCNT)   ? {16'h0, err_cnt} :
    (i_haddr[7:0] == lcrqs_pkg::ADDR_SCAN_DIV) ? scan_div : 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hrdata <= 32'h0;
    end else if (addr_take && !i_hwrite) begin
      o_hrdata <= rd_mux;
    end
  end

  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_rlo;
  logic wr_rhi;
  logic wr_div;
  assign wr_ctrl   = wr_pend && (wr_addr == lcrqs_pkg::ADDR_CTRL);
  assign wr_status = wr_pend && (wr_addr == lcrqs_pkg::ADDR_STATUS);
  assign wr_mask   = wr_pend && (wr_addr == lcrqs_pkg::ADDR_MASK);
  assign wr_rlo    = wr_pend && (wr_addr == lcrqs_pkg::ADDR_REF_LOW);
  assign wr_rhi    = wr_pend && (wr_addr == lcrqs_pkg::ADDR_REF_HIGH);
  assign wr_div    = wr_pend && (wr_addr == lcrqs_pkg::ADDR_SCAN_DIV);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_en     <= 1'b0;
      recal_mode <= 1'b0;
      mask       <= lcrqs_pkg::MASK_RST;
      ref_low    <= lcrqs_pkg::REF_LOW_RST;
      ref_high   <= lcrqs_pkg::REF_HIGH_RST;
      scan_div   <= lcrqs_pkg::SCAN_DIV_RST;
    end else begin
      if (wr_ctrl) begin
        run_en     <= i_hwdata[lcrqs_pkg::CTRL_RUN_BIT];
        recal_mode <= i_hwdata[lcrqs_pkg::CTRL_RECAL_BIT];
      end
      if (wr_mask) mask <= i_hwdata[2:0];
      if (wr_rlo) ref_low <= i_hwdata[11:0];
      if (wr_rhi) ref_high <= i_hwdata[11:0];
      if (wr_div) scan_div <= i_hwdata;
    end
  end

  // ----------------------------------------------------------------------
  // scan sequencer: one trigger per period, channels one after another
  // ----------------------------------------------------------------------
  lcrqs_pkg::lcrqs_scan_t scan_st;
  logic [31:0] tick_cnt;
  logic        tick;
  logic        scan_end;

  assign tick     = run_en && (tick_cnt >= scan_div - 32'h1);
  assign scan_end = (scan_st == lcrqs_pkg::LCRQS_DONE);

  always_ff @(posedge i_clk) begin
    if (i_rst || !run_en || tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scan_st <= lcrqs_pkg::LCRQS_IDLE;
    end else begin
      case (scan_st)
        lcrqs_pkg::LCRQS_IDLE: if (tick) scan_st <= lcrqs_pkg::LCRQS_CH0;
        lcrqs_pkg::LCRQS_CH0:
          if (i_level_valid) scan_st <= lcrqs_pkg::LCRQS_CH1;
        lcrqs_pkg::LCRQS_CH1:
          if (i_level_valid) scan_st <= lcrqs_pkg::LCRQS_DONE;
        lcrqs_pkg::LCRQS_DONE: scan_st <= lcrqs_pkg::LCRQS_IDLE;
        default: scan_st <= lcrqs_pkg::LCRQS_IDLE;
      endcase
    end
  end

  assign o_excite  = (scan_st == lcrqs_pkg::LCRQS_CH0) ||
                     (scan_st == lcrqs_pkg::LCRQS_CH1);
  assign o_sel_ch1 = (scan_st == lcrqs_pkg::LCRQS_CH1);

  // ----------------------------------------------------------------------
  // channel slices
  // ----------------------------------------------------------------------
  logic [1:0] chan_bit;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      lcrqs_chan_if cif ();
      assign cif.level    = i_level;
      assign cif.ref_low  = ref_low;
      assign cif.ref_high = ref_high;
      assign cif.sample   = i_level_valid && (gi == 0 ?
                            scan_st == lcrqs_pkg::LCRQS_CH0 :
                            scan_st == lcrqs_pkg::LCRQS_CH1);
      assign chan_bit[gi] = cif.bit_out;
      lcrqs_hyst u_hyst (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .ch    (cif.slice)
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // quadrature decode at scan end
  // ----------------------------------------------------------------------
  logic [1:0] prev_state;
  logic       step_fwd;
  logic       step_back;
  logic       step_bad;

  // forward order 11 -> 01 -> 00 -> 10 -> 11
  function automatic logic [1:0] lcrqs_succ(input logic [1:0] s);
    case (s)
      2'h3:    lcrqs_succ = 2'h1;
      2'h1:    lcrqs_succ = 2'h0;
      2'h0:    lcrqs_succ = 2'h2;
      default: lcrqs_succ = 2'h3;
    endcase
  endfunction

  assign step_fwd  = scan_end && (chan_bit == lcrqs_succ(prev_state));
  assign step_back = scan_end && (prev_state == lcrqs_succ(chan_bit));
  assign step_bad  = scan_end && (chan_bit == ~prev_state);
  assign o_state   = prev_state;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_state <= 2'h3;
      position   <= 16'h0;
      err_cnt    <= 16'h0;
    end else if (scan_end) begin
      prev_state <= chan_bit;
      if (step_fwd) position <= position + 16'h1;
      else if (step_back) position <= position - 16'h1;
      if (step_bad) err_cnt <= err_cnt + 16'h1;
    end
  end

  // ----------------------------------------------------------------------
  // sticky status, write one to clear, set wins; masked irq
  // ----------------------------------------------------------------------
  logic [2:0] ev;
  logic [2:0] clr;
  assign ev[lcrqs_pkg::ST_MOTION_BIT]   = step_fwd || step_back;
  assign ev[lcrqs_pkg::ST_SCAN_END_BIT] = scan_end;
  assign ev[lcrqs_pkg::ST_ERROR_BIT]    = step_bad;
  assign clr = wr_status ? i_hwdata[2:0] : 3'h0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status <= 3'h0;
    end else begin
      status <= ev | (status & ~clr);
    end
  end

  // run mode: motion only; recal mode: scan end only
  logic [2:0] wake_sel;
  assign wake_sel = recal_mode ? 3'h2 : 3'h1;
  assign o_irq    = |(status & mask & wake_sel);

endmodule

/* lcrqs_properties.sv */
// checker on the sampler top ports
`timescale 1ns/100ps
module lcrqs_properties (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [11:0] i_level,
  input wire logic        i_level_valid,
  input wire logic        o_excite,
  input wire logic        o_sel_ch1,
  input wire logic [1:0]  o_state,
  input wire logic        o_irq,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [11:0] lv0, lv1;
  logic        exc_q, exc_qq, wph;
  wire         upd = exc_qq && !exc_q;
  wire         tk0 = o_excite && i_level_valid && !o_sel_ch1;
  wire         tk1 = o_excite && i_level_valid && o_sel_ch1;
  // ------
  // scan tracking
  // ------
  always_ff @(posedge i_clk) begin
    exc_q  <= !i_rst && o_excite;
    exc_qq <= !i_rst && exc_q;
    wph    <= !i_rst && i_hsel && i_htrans[1] && i_hwrite && i_hready;
    if (tk0) lv0 <= i_level;
    if (tk1) lv1 <= i_level;
  end
  function automatic logic nbit(logic [11:0] lv, logic old);
    return lv < lcrqs_pkg::REF_LOW_RST ? 1'b0 :
           lv > lcrqs_pkg::REF_HIGH_RST ? 1'b1 : old;
  endfunction
  sequence s_close;
    tk1 ##1 !o_excite;
  endsequence
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus slave not ready with okay");
  a_ch0_hyst: assert property (
    s_close |=> o_state[0] == nbit(lv0, $past(o_state[0])))
    else $error("channel zero bit wrong after scan");
  a_ch1_hyst: assert property (
    s_close |=> o_state[1] == nbit(lv1, $past(o_state[1])))
    else $error("channel one bit wrong after scan");
  a_state_held: assert property (
    !upd |-> $stable(o_state)) else $error("state moved outside scan end");
  a_irq_cause: assert property (
    $rose(o_irq) |-> upd || $past(wph)) else $error("irq rose uncaused");
  a_ch1_next: assert property (
    tk0 |=> o_excite && o_sel_ch1) else $error("channel one not next");
  a_excite_wait: assert property (
    o_excite && !i_level_valid |=> o_excite && $stable(o_sel_ch1))
    else $error("measure dropped before sample");
  a_scan_order: assert property (
    $rose(o_excite) |-> !o_sel_ch1) else $error("scan began on channel one");
endmodule
bind lcrqs_top lcrqs_properties lcrqs_properties_i (.i_clk, .i_rst,
  .i_level, .i_level_valid, .o_excite, .o_sel_ch1, .o_state, .o_irq,
  .i_hsel, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hresp);

/* lcrqs_sensor_pair.sv */
// behavioural pair of lc sensors facing the sampler
`timescale 1ns/100ps
module lcrqs_sensor_pair (
  input  wire logic        i_clk,
  input  wire logic        i_excite,
  input  wire logic        i_sel_ch1,
  input  wire logic [11:0] i_lvl0,
  input  wire logic [11:0] i_lvl1,
  input  wire logic [3:0]  i_delay,
  output logic             o_valid,
  output logic [11:0]      o_level
);
  logic [3:0] cnt = 4'h0;
  initial o_valid = 1'b0;
  initial o_level = 12'h000;
  // low level over metal, high over nonmetal
  always @(posedge i_clk) begin
    if (i_excite && !o_valid && cnt == i_delay) begin
      o_valid <= 1'b1;
      o_level <= i_sel_ch1 ? i_lvl1 : i_lvl0;
      cnt     <= 4'h0;
    end else begin
      o_valid <= 1'b0;
      o_level <= ~o_level;  // no stale level outside a sample
      cnt     <= (i_excite && !o_valid) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the lc rotation quadrature sampler
`timescale 1ns/100ps
module testbench;
  localparam logic [11:0] HI = 12'hA00, LO = 12'h600, MID = 12'h800;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [11:0] lvl0 = HI, lvl1 = HI;
  logic [3:0]  dly = 4'h0;
  wire  [11:0] level;
  wire  [1:0]  state;
  wire  [31:0] hrdata;
  wire         valid, excite, sel1, irq, hrdy, hresp;
  int          fails = 0, n_tests = 0;
  logic [31:0] rstv [9] = '{32'h0, 32'h0, 32'h0,
    {20'h0, lcrqs_pkg::REF_LOW_RST}, {20'h0, lcrqs_pkg::REF_HIGH_RST},
    32'h30000, 32'h0, lcrqs_pkg::SCAN_DIV_RST, 32'h0};
  always #2 clk = ~clk;
  lcrqs_top lcrqs_top_i (.i_clk(clk), .i_rst(rst), .i_level(level),
    .i_level_valid(valid), .o_excite(excite), .o_sel_ch1(sel1),
    .o_state(state), .o_irq(irq), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp));
  lcrqs_sensor_pair lcrqs_sensor_pair_i (.i_clk(clk), .i_excite(excite),
    .i_sel_ch1(sel1), .i_lvl0(lvl0), .i_lvl1(lvl1), .i_delay(dly),
    .o_valid(valid), .o_level(level));
  // ------
  // tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  task automatic scans(input int n);
    repeat (n) @(negedge excite);
    repeat (3) @(posedge clk);
  endtask
  // channel 0 then channel 1 level; expected state after two scans
  task automatic step(input logic [11:0] a, b, input logic [1:0] s);
    lvl0 <= a;
    lvl1 <= b;
    scans(2);
    check({30'h0, state}, {30'h0, s});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------
  // tests
  // ------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rchk(8'(i * 4), rstv[i]);
    bus(1'b1, lcrqs_pkg::ADDR_REF_LOW, 32'h5A5);
    rchk(lcrqs_pkg::ADDR_REF_LOW, 32'h5A5);
    bus(1'b1, lcrqs_pkg::ADDR_REF_HIGH, 32'hFA5A);
    rchk(lcrqs_pkg::ADDR_REF_HIGH, 32'hA5A);
    bus(1'b1, lcrqs_pkg::ADDR_REF_LOW, {20'h0, lcrqs_pkg::REF_LOW_RST});
    bus(1'b1, lcrqs_pkg::ADDR_REF_HIGH, {20'h0, lcrqs_pkg::REF_HIGH_RST});
    bus(1'b1, lcrqs_pkg::ADDR_SCAN_DIV, 32'h32);
    bus(1'b1, lcrqs_pkg::ADDR_MASK, 32'h7);
    bus(1'b1, lcrqs_pkg::ADDR_CTRL, 32'h1);
    scans(2);
    irq_is(1'b0);
    rchk(lcrqs_pkg::ADDR_STATUS, 32'h2);
    dly <= 4'h6;
    step(MID, LO, 2'h1);
    step(LO, LO, 2'h0);
    step(MID, HI, 2'h2);
    step(HI, MID, 2'h3);
    rchk(lcrqs_pkg::ADDR_POSITION, 32'h30004);
    irq_is(1'b1);
    bus(1'b1, lcrqs_pkg::ADDR_STATUS, 32'h7);
    irq_is(1'b0);
    dly <= 4'h0;
    step(LO, HI, 2'h2);
    step(HI, LO, 2'h1);
    rchk(lcrqs_pkg::ADDR_POSITION, 32'h10003);
    rchk(lcrqs_pkg::ADDR_ERRCNT, 32'h1);
    rchk(lcrqs_pkg::ADDR_STATUS, 32'h7);
    bus(1'b1, lcrqs_pkg::ADDR_CTRL, 32'h3);
    bus(1'b1, lcrqs_pkg::ADDR_STATUS, 32'h2);
    irq_is(1'b0);
    scans(1);
    irq_is(1'b1);
    bus(1'b1, lcrqs_pkg::ADDR_MASK, 32'h1);
    irq_is(1'b0);
    bus(1'b1, lcrqs_pkg::ADDR_CTRL, 32'h1);
    irq_is(1'b1);
    bus(1'b1, lcrqs_pkg::ADDR_MASK, 32'h0);
    irq_is(1'b0);
    complete_run;
  end
  // run needs under a thousand cycles; this allows over 25 times that
  initial begin
    #100000;
    fails++;
    complete_run;
  end
endmodule
